// File: pkg/wdg_pkg.sv
// shared constants and types of the watchdog with halt control
package wdg_pkg;
	localparam int           ADDR_W        = 8;
	localparam int           DATA_W        = 8;
	localparam int           CNT_W         = 7;
	localparam [ADDR_W-1:0]  REG_WDG_CTRL  = 8'h2A;
	localparam [DATA_W-1:0]  CTRL_RESET    = 8'h7F;
	localparam int           ACT_BIT       = 7;
	localparam int           TOP_BIT       = 6;
	localparam [CNT_W-1:0]   ROLL_FROM     = 7'h40;
	localparam int           TICK_DEFAULT  = 16384;
	localparam int           DLY_W         = 13;
	localparam [DLY_W-1:0]   WAKE_SHORT    = 13'h0100;
	localparam [DLY_W-1:0]   WAKE_LONG     = 13'h1000;
	localparam int           CLK_PERIOD_PS = 25000;
	localparam int           RST_PULSE_US  = 30;
	localparam int           RST_PULSE_CYC =
		(RST_PULSE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int           PULSE_W       = 11;
	localparam int           STRAP_W       = 3;
	localparam int           STRAP_HW_ON   = 0;
	localparam int           STRAP_HALTRST = 1;
	localparam int           STRAP_LONGDLY = 2;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_HALT_LAST,
		ST_HALT_FROZEN,
		ST_ACTIVE_HALT,
		ST_WAKE_DELAY
	} wdg_state_type;
endpackage

// File: src/wdg_prescaler.sv
// divider, paused while run is low, giving one tick per watchdog decrement period
`timescale 1ns/1ps
module wdg_prescaler #(
	parameter int DIV = wdg_pkg::TICK_DEFAULT
) (
	input  wire logic sys_clk,
	input  wire logic rst_b,
	input  wire logic run,
	output logic      tick
);
	localparam int W = $clog2(DIV);

	logic [W-1:0] div_q;

	if (DIV < 2) begin
		$error("wdg_prescaler: DIV must be at least 2");
	end

	// phase is never cleared by a refresh write, so the first period
	// after a write is anywhere between one and DIV cycles
	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			div_q <= '0;
		else if (run) begin
			if (div_q == W'(DIV - 1))
				div_q <= '0;
			else
				div_q <= div_q + W'(1);
		end
	end

	assign tick = run && (div_q == W'(DIV - 1));
endmodule

// File: src/wdg_halt_ctrl.sv
// watchdog downcounter with control register and halt handling
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
//
// Operation
// - Plain halt (rtc enable 0, halt reset option 0) raises no reset, decrements once more, then freezes until an interrupt or reset.
// - Waking from plain halt by external interrupt resumes counting only after 256 or 4096 cycles.
// - A reset that ends halt returns the watchdog to disabled unless the always-on option is set.
// - Halt with rtc enable 0 and halt reset option 1 produces a reset instead of halting.
// - Halt with rtc enable 1 enters active halt without reset and the counter holds still.
// - Leaving active halt by rtc or external interrupt resumes counting at once.
// - Leaving active halt by reset resumes counting only after 256 or 4096 cycles.
// - The always-on option keeps the watchdog active and ignores the activation bit.
// - The activation bit 7 is set by software, writing zero does nothing, only reset clears it.
// - The 7-bit counter in bits 6:0 decrements once per 16384 oscillator cycles.
// - While active, the counter stepping from 40h to 3Fh produces a reset, except on the last step of plain halt.
// - The counter decrements even when the watchdog is not activated.
// - A write with the activation bit set and the counter top bit clear resets at once.
// - A watchdog reset drives the reset line low for typically 30 us.
module wdg_halt_ctrl #(
	parameter int TICK_CYCLES = wdg_pkg::TICK_DEFAULT
) (
	input  wire logic                       sys_clk,
	input  wire logic                       rst_b,
	input  wire logic [wdg_pkg::ADDR_W-1:0] regAddr,
	input  wire logic [wdg_pkg::DATA_W-1:0] regWrData,
	input  wire logic                       regWrEn,
	input  wire logic                       regRdEn,
	output logic      [wdg_pkg::DATA_W-1:0] regRdData,
	input  wire logic                       haltExec,
	input  wire logic                       rtcInterruptEnable,
	input  wire logic                       rtcWake,
	input  wire logic                       extIntWake,
	input  wire logic                       hwAlwaysOnPin,
	input  wire logic                       haltResetOptionPin,
	input  wire logic                       wakeDelayLongPin,
	output logic                            resetPinOut,
	output logic                            resetPinOe
);
	import wdg_pkg::*;

	if (TICK_CYCLES < 2) begin
		$error("wdg_halt_ctrl: TICK_CYCLES must be at least 2");
	end

	wdg_state_type        state_q;
	logic [CNT_W-1:0]     count_q;
	logic                 activation_q;
	logic [DLY_W-1:0]     delayCnt_q;
	logic [PULSE_W-1:0]   pulseLeft_q;
	logic                 pulseOn_q;
	logic [DATA_W-1:0]    rdData_q;
	logic [STRAP_W-1:0]   strapMeta_q;
	logic [STRAP_W-1:0]   strap_q;
	logic                 extMeta_q;
	logic                 extWake_q;
	logic                 tick;
	logic                 preRun;
	logic                 ctrlWrite;
	logic                 wdgActive;
	logic                 hwAlwaysOn;
	logic                 haltResetOption;
	logic [DLY_W-1:0]     wakeLimit;
	logic                 delayDone;
	logic                 rollTrig;
	logic                 swTrig;
	logic                 haltTrig;
	logic                 resetTrig;
	logic                 wakeDelayLong;

	// pins and option straps come from outside the clock domain
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			strapMeta_q <= '0;
			strap_q     <= '0;
			extMeta_q   <= 1'b0;
			extWake_q   <= 1'b0;
		end else begin
			strapMeta_q <= {wakeDelayLongPin, haltResetOptionPin,
				hwAlwaysOnPin};
			strap_q     <= strapMeta_q;
			extMeta_q   <= extIntWake;
			extWake_q   <= extMeta_q;
		end
	end

	assign hwAlwaysOn      = strap_q[STRAP_HW_ON];
	assign haltResetOption = strap_q[STRAP_HALTRST];
	// strap is static: a change in mid-delay moves the end point
	assign wakeDelayLong   = strap_q[STRAP_LONGDLY];
	assign wakeLimit       = wakeDelayLong ? WAKE_LONG : WAKE_SHORT;

	assign ctrlWrite = regWrEn && (regAddr == REG_WDG_CTRL);
	assign wdgActive = activation_q || hwAlwaysOn;

	// frozen in active halt, plain halt after its last step, and wake-up delay
	assign preRun = (state_q == ST_RUN) || (state_q == ST_HALT_LAST);

	wdg_prescaler #(
		.DIV (TICK_CYCLES)
	) wdg_prescaler_inst (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.run     (preRun),
		.tick    (tick)
	);

	assign delayDone = (delayCnt_q == wakeLimit - DLY_W'(1));

	// no slow or wait input exists: those modes cannot change counting
	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			state_q <= ST_WAKE_DELAY;
		else begin
			unique case (state_q)
				ST_RUN: begin
					if (haltExec) begin
						if (rtcInterruptEnable)
							state_q <= ST_ACTIVE_HALT;
						else if (!haltResetOption)
							state_q <= ST_HALT_LAST;
					end
				end
				ST_HALT_LAST: begin
					if (extWake_q)
						state_q <= ST_WAKE_DELAY;
					else if (tick)
						state_q <= ST_HALT_FROZEN;
				end
				ST_HALT_FROZEN: begin
					if (extWake_q)
						state_q <= ST_WAKE_DELAY;
				end
				ST_ACTIVE_HALT: begin
					if (rtcWake || extWake_q)
						state_q <= ST_RUN;
				end
				ST_WAKE_DELAY: begin
					if (delayDone)
						state_q <= ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			delayCnt_q <= '0;
		else if (state_q == ST_WAKE_DELAY && !delayDone)
			delayCnt_q <= delayCnt_q + DLY_W'(1);
		else
			delayCnt_q <= '0;
	end

	// a refresh write wins over a tick in the same cycle
	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			count_q <= CTRL_RESET[CNT_W-1:0];
		else if (ctrlWrite)
			count_q <= regWrData[CNT_W-1:0];
		else if (tick)
			count_q <= count_q - CNT_W'(1);
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			activation_q <= CTRL_RESET[ACT_BIT];
		else if (ctrlWrite && regWrData[ACT_BIT])
			activation_q <= 1'b1;
	end

	// rollover only counts in run; the last plain-halt step is harmless
	assign rollTrig = tick && (state_q == ST_RUN) && !ctrlWrite
		&& wdgActive && (count_q == ROLL_FROM);
	assign swTrig   = ctrlWrite && regWrData[ACT_BIT]
		&& !regWrData[TOP_BIT];
	assign haltTrig = haltExec && (state_q == ST_RUN)
		&& !rtcInterruptEnable && haltResetOption;
	assign resetTrig = rollTrig || swTrig || haltTrig;

	// the reset request is the only output action, no interrupt
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			pulseOn_q   <= 1'b0;
			pulseLeft_q <= '0;
		end else if (!pulseOn_q) begin
			if (resetTrig) begin
				pulseOn_q   <= 1'b1;
				pulseLeft_q <= PULSE_W'(RST_PULSE_CYC);
			end
		end else begin
			pulseLeft_q <= pulseLeft_q - PULSE_W'(1);
			if (pulseLeft_q == PULSE_W'(1))
				pulseOn_q <= 1'b0;
		end
	end

	// open-drain line: only ever pulled low
	assign resetPinOut = 1'b0;
	assign resetPinOe  = pulseOn_q;

	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			rdData_q <= '0;
		else if (regRdEn && regAddr == REG_WDG_CTRL)
			rdData_q <= {activation_q, count_q};
		else
			rdData_q <= '0;
	end

	assign regRdData = rdData_q;

	// ---- checks ----
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	logic [PULSE_W-1:0] pulseLen_q;

	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			pulseLen_q <= '0;
		else if (pulseOn_q)
			pulseLen_q <= pulseLen_q + PULSE_W'(1);
		else
			pulseLen_q <= '0;
	end

	// reference length of each wake delay, kept apart from delayCnt_q
	logic [DLY_W-1:0]   wakeLen_q;

	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			wakeLen_q <= '0;
		else if (state_q == ST_WAKE_DELAY)
			wakeLen_q <= wakeLen_q + DLY_W'(1);
		else
			wakeLen_q <= '0;
	end

	property p_frozen_holds;
		(state_q == ST_HALT_FROZEN) && !ctrlWrite |=>
			$stable(count_q) && !rollTrig;
	endproperty

	plain_halt_freeze_a: assert property (p_frozen_holds)
		else $error("counter moved or reset raised in plain halt");

	wake_delay_hold_a: assert property (
		(state_q == ST_HALT_FROZEN) && extWake_q |=>
			(state_q == ST_WAKE_DELAY) && !tick [*8])
		else $error("plain halt wake did not wait");

	reset_disables_a: assert property (
		$rose(rst_b) |-> !activation_q)
		else $error("activation survived reset");

	halt_reset_a: assert property (
		haltTrig && !pulseOn_q |=> pulseOn_q && state_q == ST_RUN)
		else $error("halt with reset option did not reset");

	active_halt_hold_a: assert property (
		(state_q == ST_ACTIVE_HALT) && !ctrlWrite |=> $stable(count_q))
		else $error("counter moved in active halt");

	active_exit_a: assert property (
		(state_q == ST_ACTIVE_HALT) && (rtcWake || extWake_q) |=>
			state_q == ST_RUN)
		else $error("active halt exit was delayed");

	startup_delay_a: assert property (
		$rose(rst_b) |-> (state_q == ST_WAKE_DELAY) ##1
			(state_q == ST_WAKE_DELAY) [*8])
		else $error("counting resumed without delay after reset");

	always_on_a: assert property (
		hwAlwaysOn && tick && state_q == ST_RUN && !ctrlWrite
			&& count_q == ROLL_FROM && !pulseOn_q |=> pulseOn_q)
		else $error("always-on watchdog did not reset");

	activation_sticky_a: assert property (
		activation_q |=> activation_q)
		else $error("activation bit cleared without reset");

	tick_decrement_a: assert property (
		tick && !ctrlWrite |=> count_q == $past(count_q) - CNT_W'(1))
		else $error("counter missed a decrement");

	rollover_reset_a: assert property (
		rollTrig && !pulseOn_q |=> pulseOn_q ##0
			count_q[TOP_BIT] == 1'b0)
		else $error("rollover did not reset");

	sw_reset_a: assert property (
		swTrig && !pulseOn_q |=> pulseOn_q)
		else $error("software reset write ignored");

	pulse_length_a: assert property (
		$fell(pulseOn_q) |-> $past(pulseLen_q) ==
			PULSE_W'(RST_PULSE_CYC - 1))
		else $error("reset pulse length wrong");

	wake_length_a: assert property (
		(state_q == ST_RUN) && ($past(state_q) == ST_WAKE_DELAY) |->
			$past(wakeLen_q) == (wakeDelayLong
			? WAKE_LONG - DLY_W'(1) : WAKE_SHORT - DLY_W'(1)))
		else $error("wake delay length wrong");

	halt_last_step_a: assert property (
		(state_q == ST_HALT_LAST) && tick && !extWake_q |=>
			state_q == ST_HALT_FROZEN)
		else $error("plain halt did not freeze after its last step");

	free_run_a: assert property (
		tick && !ctrlWrite && !wdgActive |=>
			count_q != $past(count_q))
		else $error("inactive counter stopped");

	inactive_quiet_a: assert property (
		tick && (count_q == ROLL_FROM) && !wdgActive && !ctrlWrite
			&& !haltTrig && !pulseOn_q |=> !pulseOn_q)
		else $error("inactive watchdog raised a reset");

	// software sees the stored bit and counter, never the strap
	read_back_a: assert property (
		regRdEn && (regAddr == REG_WDG_CTRL) |=>
			regRdData == {$past(activation_q), $past(count_q)})
		else $error("register read back wrong");

	read_idle_a: assert property (
		!(regRdEn && (regAddr == REG_WDG_CTRL)) |=> regRdData == '0)
		else $error("read data not cleared");

	pulse_cover_c: cover property ($rose(pulseOn_q));
	active_halt_c: cover property (
		state_q == ST_ACTIVE_HALT ##1 state_q == ST_RUN);
	plain_wake_c: cover property (
		state_q == ST_HALT_FROZEN ##1 state_q == ST_WAKE_DELAY);
	long_delay_c: cover property (
		wakeDelayLong && state_q == ST_WAKE_DELAY ##1 state_q == ST_RUN);
	halt_option_c: cover property (haltTrig);
endmodule

// File: sim/wdg_halt_ctrl_tb_top.sv
// self-checking bench of the watchdog with halt control
`timescale 1ns/1ps
module wdg_halt_ctrl_tb_top;
	import wdg_pkg::*;
	// short tick keeps the run small; expectations scale with it
	localparam int TK = 16;
	logic       sys_clk   = 1'b0;
	logic       rst_b     = 1'b0;
	logic [7:0] regAddr   = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic       regWrEn   = 1'b0;
	logic       regRdEn   = 1'b0;
	logic [7:0] regRdData;
	logic       haltExec  = 1'b0;
	logic       rtcIe     = 1'b0;
	logic       rtcWake   = 1'b0;
	logic       extWake   = 1'b0;
	logic       hwOn      = 1'b0;
	logic       haltOpt   = 1'b0;
	logic       longDly   = 1'b0;
	logic       resetPinOut;
	logic       resetPinOe;
	int         err_total = 0;
	int         checked   = 0;
	int         cycles    = 0;
	int         pulses    = 0;
	int         p0;
	int         n;
	logic [7:0] lfsr      = 8'h5B;
	logic [7:0] v;
	logic [7:0] w;

	wdg_halt_ctrl #(.TICK_CYCLES(TK)) wdg_halt_ctrl_inst (
		.sys_clk           (sys_clk),
		.rst_b             (rst_b),
		.regAddr           (regAddr),
		.regWrData         (regWrData),
		.regWrEn           (regWrEn),
		.regRdEn           (regRdEn),
		.regRdData         (regRdData),
		.haltExec          (haltExec),
		.rtcInterruptEnable(rtcIe),
		.rtcWake           (rtcWake),
		.extIntWake        (extWake),
		.hwAlwaysOnPin     (hwOn),
		.haltResetOptionPin(haltOpt),
		.wakeDelayLongPin  (longDly),
		.resetPinOut       (resetPinOut),
		.resetPinOe        (resetPinOe)
	);

	always #12.5 sys_clk = ~sys_clk;

	always @(posedge resetPinOe) pulses++;

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles > 20000) begin
			err_total++;
			print_verdict();
		end
	end

	function automatic logic [7:0] nextRand(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction

	task automatic print_verdict();
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask

	task automatic doReset();
		@(posedge sys_clk);
		rst_b <= 1'b0;
		repeat (10) @(posedge sys_clk);
		rst_b <= 1'b1;
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge sys_clk);
		regWrEn <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge sys_clk);
		regRdEn <= 1'b0;
		#1;
		d = regRdData;
	endtask

	task automatic halt();
		@(posedge sys_clk);
		haltExec <= 1'b1;
		@(posedge sys_clk);
		haltExec <= 1'b0;
		#1;
	endtask

	// bounded wait; the pulse is then checked by the caller
	task automatic waitOe(input int lim);
		n = 0;
		while (resetPinOe !== 1'b1 && n < lim) begin
			cyc(1);
			n++;
		end
	endtask

	initial begin
		doReset();
		rd(REG_WDG_CTRL, v);
		chk("ctrl_reset", CTRL_RESET, v);
		rd(8'h2B, v);
		chk("unmapped_rd", 8'h00, v);
		cyc(1700);
		rd(REG_WDG_CTRL, v);
		chk("free_run", 8'h00, v & 8'hC0);
		chk("idle_no_rst", 0, pulses);
		wr(REG_WDG_CTRL, 8'hFF);
		wr(REG_WDG_CTRL, 8'h7F);
		rd(REG_WDG_CTRL, v);
		chk("act_sticky", 8'h80, v & 8'h80);
		for (int i = 0; i < 24; i++) begin
			lfsr = nextRand(lfsr);
			w = 8'hC8 | lfsr;
			wr(REG_WDG_CTRL, w);
			// unmapped write that would be a software reset if decoded
			if (lfsr[0])
				wr(8'h2A ^ {lfsr[7:1], 1'b1}, 8'h80 | (lfsr & 8'h3F));
			rd(REG_WDG_CTRL, v);
			chk("refresh", w, (v === w - 8'h01) ? w : v);
		end
		chk("bus_no_rst", 0, pulses);
		wr(REG_WDG_CTRL, 8'hFF);
		cyc(TK * 4);
		rd(REG_WDG_CTRL, v);
		chk("tick_rate", 8'hFB, (v === 8'hFA) ? 8'hFB : v);
		wr(REG_WDG_CTRL, 8'hC1);
		waitOe(2 * TK + 8);
		chk("roll_rst", 1, resetPinOe);
		chk("rst_out", 0, resetPinOut);
		n = 0;
		while (resetPinOe === 1'b1 && n < 2000) begin
			cyc(1);
			n++;
		end
		chk("pulse_len", 16'(RST_PULSE_CYC), 16'(n));
		doReset();
		wr(REG_WDG_CTRL, 8'hBF);
		waitOe(2);
		chk("sw_rst", 1, resetPinOe);
		doReset();
		cyc(300);
		wr(REG_WDG_CTRL, 8'hFF);
		@(posedge sys_clk);
		rtcIe <= 1'b1;
		halt();
		rd(REG_WDG_CTRL, v);
		cyc(100);
		rd(REG_WDG_CTRL, w);
		chk("act_halt_hold", v, w);
		chk("act_halt_oe", 0, resetPinOe);
		@(posedge sys_clk);
		rtcWake <= 1'b1;
		@(posedge sys_clk);
		rtcWake <= 1'b0;
		cyc(2 * TK + 2);
		rd(REG_WDG_CTRL, w);
		chk("act_wake", 1, w < v);
		halt();
		doReset();
		cyc(200);
		rd(REG_WDG_CTRL, v);
		chk("halt_rst_hold", CTRL_RESET, v);
		@(posedge sys_clk);
		rtcIe <= 1'b0;
		cyc(80);
		p0 = pulses;
		// final decrement lands on 40 or 3F; neither may reset in halt
		wr(REG_WDG_CTRL, 8'hC1);
		halt();
		cyc(3 * TK);
		rd(REG_WDG_CTRL, v);
		cyc(150);
		rd(REG_WDG_CTRL, w);
		chk("halt_frozen", v, w);
		chk("halt_no_rst", p0, pulses);
		@(posedge sys_clk);
		extWake <= 1'b1;
		repeat (4) @(posedge sys_clk);
		extWake <= 1'b0;
		cyc(200);
		rd(REG_WDG_CTRL, w);
		chk("wake_wait", v, w);
		cyc(100 + 2 * TK);
		rd(REG_WDG_CTRL, w);
		chk("wake_resume", 1, w < v);
		@(posedge sys_clk);
		haltOpt <= 1'b1;
		doReset();
		cyc(300);
		halt();
		waitOe(2);
		chk("halt_opt_rst", 1, resetPinOe);
		@(posedge sys_clk);
		haltOpt <= 1'b0;
		hwOn <= 1'b1;
		doReset();
		waitOe(256 + 66 * TK);
		chk("hw_on_rst", 1, resetPinOe);
		@(posedge sys_clk);
		hwOn <= 1'b0;
		longDly <= 1'b1;
		doReset();
		// long strap: still frozen well past the short delay
		cyc(3000);
		rd(REG_WDG_CTRL, v);
		chk("long_wait", CTRL_RESET, v);
		cyc(1200);
		rd(REG_WDG_CTRL, v);
		chk("long_resume", 1, v < CTRL_RESET);
		print_verdict();
	end
endmodule
